/* File: monitor_cfg_pkg.sv */
// Register map, field layout and reset values of the conversion and fan configuration bank
package monitor_cfg_pkg;
	localparam logic [7:0] conv_ctrl_idx = 8'h16;
	localparam logic [7:0] atten_a_idx = 8'h18;
	localparam logic [7:0] atten_b_idx = 8'h19;
	localparam logic [7:0] quiet_ramp_idx = 8'h1a;
	localparam logic [7:0] sys_ctrl_idx = 8'h40;
	localparam logic [7:0] status_idx = 8'h41;
	localparam int addr_width = 10;
	localparam logic [7:0] conv_ctrl_reset = 8'h00;
	localparam logic [7:0] atten_a_reset = 8'hff;
	localparam logic [7:0] atten_b_reset = 8'h37;
	localparam logic [7:0] quiet_ramp_reset = 8'h00;
	localparam logic [7:0] atten_a_write_mask = 8'hfe;
	localparam logic [7:0] atten_a_fixed_bits = 8'h01;
	localparam int aux_first_bit = 0;
	localparam int aux_second_bit = 1;
	localparam int single_mode_bit = 2;
	localparam int chan_lsb = 3;
	localparam int chan_msb = 7;
	localparam int quiet_en_one_bit = 0;
	localparam int quiet_en_two_bit = 1;
	localparam int ramp_one_lsb = 2;
	localparam int ramp_one_msb = 4;
	localparam int ramp_two_lsb = 5;
	localparam int ramp_two_msb = 7;
	localparam int sys_lock_bit = 0;
	localparam int sys_swreset_bit = 1;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	localparam logic [4:0] chan_pin26 = 5'h00;
	localparam logic [4:0] chan_remote_one = 5'h01;
	localparam logic [4:0] chan_remote_two = 5'h02;
	localparam logic [4:0] chan_remote_three = 5'h03;
	localparam logic [4:0] chan_local = 5'h04;
	localparam logic [4:0] chan_12v1 = 5'h05;
	localparam logic [4:0] chan_12v2 = 5'h06;
	localparam logic [4:0] chan_12v3 = 5'h07;
	localparam logic [4:0] chan_3v3 = 5'h08;
	localparam logic [4:0] chan_pin15 = 5'h09;
	localparam logic [4:0] chan_pin19 = 5'h0a;
	localparam logic [4:0] chan_5v = 5'h0b;
	localparam logic [4:0] chan_pin23 = 5'h0c;
	localparam logic [4:0] chan_pin24 = 5'h0d;
	localparam logic [4:0] chan_pin25 = 5'h0e;
	localparam logic [4:0] chan_1v5_one = 5'h10;
	localparam logic [4:0] chan_1v5_two = 5'h11;
	localparam logic [4:0] chan_last = 5'h11;
	localparam logic [5:0] inc_code0 = 6'h01;
	localparam logic [5:0] inc_code1 = 6'h02;
	localparam logic [5:0] inc_code2 = 6'h03;
	localparam logic [5:0] inc_code3 = 6'h05;
	localparam logic [5:0] inc_code4 = 6'h08;
	localparam logic [5:0] inc_code5 = 6'h0c;
	localparam logic [5:0] inc_code6 = 6'h18;
	localparam logic [5:0] inc_code7 = 6'h30;
	localparam int slow_factor = 4;
	localparam int slow_shift = 2;
	localparam int slow_bit = 3;
endpackage

/* File: ramp_step_decode.sv */
// Ramp code to duty increment decoder for one fan drive output
module ramp_step_decode
	import monitor_cfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] ramp_code,
	input wire logic quiet_enable,
	input wire logic slow_mode,
	output logic [5:0] step_q,
	output logic [1:0] slow_shift_q
);
	logic [5:0] step_d;
	always_comb
	begin
		case (ramp_code)
			3'h0: step_d = inc_code0;
			3'h2: step_d = inc_code2;
			3'h6: step_d = inc_code6;
			3'h1: step_d = inc_code1;
			3'h3: step_d = inc_code3;
			3'h4: step_d = inc_code4;
			3'h5: step_d = inc_code5;
			3'h7: step_d = inc_code7;
			default: step_d = inc_code0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			step_q <= 6'h00;
			slow_shift_q <= 2'h0;
		end
		else
		begin
			step_q <= quiet_enable ? step_d : 6'h00;
			slow_shift_q <= (quiet_enable && slow_mode) ? 2'(slow_shift) : 2'h0;
		end
	end
endmodule // ramp_step_decode

/* File: monitor_conversion_fan_config.sv */
// AXI4-Lite register bank for conversion, attenuator and fan acoustics configuration
// Overview of operation
// - Control bit 0 enables auxiliary drive on general pin five, reset off.
// - Control bit 1 enables auxiliary drive on general pin six, reset off.
// - Control bit 2 selects repeated conversion on one chosen channel, reset 0.
// - Channel select in bits 7:3, reset code selects pin 26 input.
// - Temperature codes: 1,2,3 remote one to three, 4 local.
// - Attenuator A bits 1..7 keep pins' attenuators in; 0 bypasses.
// - Attenuator B bits 0,1,2,4,5 control pins 23,24,25,28,29; reset 1.
// - B reserved bits writable reset 0; A bit 0 read-only.
// - Configuration registers reset on power-on and software reset; lock, cleared only at power-on, blocks their writes.
// - Acoustics bit 0 enables ramp-limited mode for fan output one.
// - Acoustics bit 1 enables ramp-limited mode for fan output two.
// - Bits 4:2 ramp code for output one, listed increments.
// - Bits 7:5 ramp code for output two, same mapping.
// - Ramp code sets climb time from 33 to 100 percent.
// - Codes 0, 2, 6 give increments 1, 3, 24.
// - Output slow bit makes the ramp four times longer.
//
// Added by the designer: register access over AXI4-Lite.
module monitor_conversion_fan_config
	import monitor_cfg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [addr_width-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [addr_width-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fan_one_slow,
	input wire logic fan_two_slow,
	input wire logic conversion_done,
	output logic aux_drive_enable_first,
	output logic aux_drive_enable_second,
	output logic [4:0] active_channel_q,
	output logic [7:0] atten_a_q,
	output logic [7:0] atten_b_q,
	output logic [5:0] fan_one_step_q,
	output logic [1:0] fan_one_shift_q,
	output logic [5:0] fan_two_step_q,
	output logic [1:0] fan_two_shift_q
);
	logic [7:0] conv_q;
	logic [7:0] ramp_q;
	logic lock_q;
	logic aw_held_q;
	logic w_held_q;
	logic [addr_width-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic do_write;
	logic soft_reset;
	logic wr_hit;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic [7:0] rd_val;
	logic rd_hit;
	assign wr_idx = 8'(awaddr_q >> 2);
	assign rd_idx = 8'(s_axi_araddr >> 2);
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_hit = (wr_idx == conv_ctrl_idx) || (wr_idx == atten_a_idx)
		|| (wr_idx == atten_b_idx) || (wr_idx == quiet_ramp_idx)
		|| (wr_idx == sys_ctrl_idx) || (wr_idx == status_idx);
	assign soft_reset = do_write && wstrb_q && (wr_idx == sys_ctrl_idx) && wdata_q[sys_swreset_bit];
	// Write address and data capture in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb_q <= s_axi_wstrb[0];
			end
			else if (do_write)
				w_held_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awready <= 1'b0;
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_awready <= 1'b1;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wready <= 1'b0;
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_wready <= 1'b1;
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// Lock is sticky until power-on reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_q <= 1'b0;
		else if (do_write && wstrb_q && wr_idx == sys_ctrl_idx && wdata_q[sys_lock_bit])
			lock_q <= 1'b1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || soft_reset)
		begin
			conv_q <= conv_ctrl_reset;
			atten_a_q <= atten_a_reset;
			atten_b_q <= atten_b_reset;
			ramp_q <= quiet_ramp_reset;
		end
		else if (do_write && wstrb_q && !lock_q)
		begin
			if (wr_idx == conv_ctrl_idx)
				conv_q <= wdata_q;
			if (wr_idx == atten_a_idx)
				atten_a_q <= (wdata_q & atten_a_write_mask) | atten_a_fixed_bits;
			if (wr_idx == atten_b_idx)
				atten_b_q <= wdata_q;
			if (wr_idx == quiet_ramp_idx)
				ramp_q <= wdata_q;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aux_drive_enable_first <= 1'b0;
			aux_drive_enable_second <= 1'b0;
		end
		else
		begin
			aux_drive_enable_first <= conv_q[aux_first_bit];
			aux_drive_enable_second <= conv_q[aux_second_bit];
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || soft_reset)
			active_channel_q <= chan_pin26;
		else if (conv_q[single_mode_bit])
			active_channel_q <= conv_q[chan_msb:chan_lsb];
		else if (conversion_done)
		begin
			// Code 15 is unused and skipped
			if (active_channel_q == chan_last)
				active_channel_q <= chan_pin26;
			else if (active_channel_q == chan_pin25)
				active_channel_q <= chan_1v5_one;
			else
				active_channel_q <= active_channel_q + 5'h01;
		end
	end
	always_comb
	begin
		rd_hit = 1'b1;
		case (rd_idx)
			conv_ctrl_idx: rd_val = conv_q;
			atten_a_idx: rd_val = atten_a_q;
			atten_b_idx: rd_val = atten_b_q;
			quiet_ramp_idx: rd_val = ramp_q;
			sys_ctrl_idx: rd_val = {7'h00, lock_q};
			status_idx: rd_val = {3'h0, active_channel_q};
			default:
			begin
				rd_val = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_val};
			s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	ramp_step_decode fan_one_decode (
		.aclk(aclk),
		.aresetn(aresetn),
		.ramp_code(ramp_q[ramp_one_msb:ramp_one_lsb]),
		.quiet_enable(ramp_q[quiet_en_one_bit]),
		.slow_mode(fan_one_slow),
		.step_q(fan_one_step_q),
		.slow_shift_q(fan_one_shift_q)
	);
	// Output two uses the same decoder
	ramp_step_decode fan_two_decode (
		.aclk(aclk),
		.aresetn(aresetn),
		.ramp_code(ramp_q[ramp_two_msb:ramp_two_lsb]),
		.quiet_enable(ramp_q[quiet_en_two_bit]),
		.slow_mode(fan_two_slow),
		.step_q(fan_two_step_q),
		.slow_shift_q(fan_two_shift_q)
	);
	// Assertions
	// Pin five enable follows bit 0
	aux_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aux_drive_enable_first == $past(conv_q[aux_first_bit]))
		else $error("aux first enable mismatch");
	aux_second_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aux_drive_enable_second == $past(conv_q[aux_second_bit]))
		else $error("aux second enable mismatch");
	single_chan_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_q[single_mode_bit] && !soft_reset |=> active_channel_q == $past(conv_q[chan_msb:chan_lsb]))
		else $error("single channel not followed");
	atten_a_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		atten_a_q[0] == 1'b1)
		else $error("attenuator A bit 0 changed");
	lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_q && !soft_reset |=> $stable(conv_q) && $stable(ramp_q) && $stable(atten_b_q))
		else $error("write while locked");
	soft_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		soft_reset |=> conv_q == conv_ctrl_reset && atten_b_q == atten_b_reset
		&& atten_a_q == atten_a_reset && ramp_q == quiet_ramp_reset)
		else $error("software reset missed defaults");
	quiet_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ramp_q[quiet_en_one_bit] |=> fan_one_step_q == 6'h00)
		else $error("fan one ramp active while disabled");
	fast_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ramp_q[quiet_en_two_bit] && ramp_q[ramp_two_msb:ramp_two_lsb] == 3'h7
		|=> fan_two_step_q == inc_code7)
		else $error("fan two fastest increment wrong");
	seq_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!conv_q[single_mode_bit] && conversion_done && active_channel_q == chan_last && !soft_reset
		|=> active_channel_q == chan_pin26)
		else $error("sequencer did not wrap");
	write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
	write_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) do_write && !lock_q);
	locked_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) do_write && lock_q);
	wrap_cover_c: cover property (@(posedge aclk) disable iff (!aresetn)
		conversion_done && active_channel_q == chan_last);
endmodule // monitor_conversion_fan_config

/* File: tb_monitor_conversion_fan_config.sv */
// Self-checking bench for the conversion and fan configuration bank
module tb_monitor_conversion_fan_config
	import monitor_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk;
	logic aresetn;
	logic [addr_width-1:0] s_axi_awaddr;
	logic [addr_width-1:0] s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp;
	logic [1:0] s_axi_rresp;
	logic fan_one_slow, fan_two_slow, conversion_done, aux_first, aux_second;
	logic [4:0] active_channel_q;
	logic [7:0] atten_a_q;
	logic [7:0] atten_b_q;
	logic [5:0] fan_one_step_q;
	logic [5:0] fan_two_step_q;
	logic [1:0] fan_one_shift_q;
	logic [1:0] fan_two_shift_q;
	int fail_count;
	int cmp_count;
	localparam logic [5:0] step_exp [8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h08, 6'h0c, 6'h18, 6'h30};

	monitor_conversion_fan_config monitor_conversion_fan_config_i (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fan_one_slow(fan_one_slow),
		.fan_two_slow(fan_two_slow), .conversion_done(conversion_done),
		.aux_drive_enable_first(aux_first), .aux_drive_enable_second(aux_second),
		.active_channel_q(active_channel_q), .atten_a_q(atten_a_q), .atten_b_q(atten_b_q),
		.fan_one_step_q(fan_one_step_q), .fan_one_shift_q(fan_one_shift_q),
		.fan_two_step_q(fan_two_step_q), .fan_two_shift_q(fan_two_shift_q)
	);

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task complete_run;
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task settle;
		repeat (3) @(negedge aclk);
	endtask

	task axi_write(input logic [addr_width-1:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic aw_hs, w_hs, b_hs;
		logic [1:0] r;
		n = 0;
		b_hs = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'h1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_hs && n < 50)
		begin
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			n++;
			@(posedge aclk);
			if (aw_hs)
				s_axi_awvalid <= 1'b0;
			if (w_hs)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		check(b_hs, 1'b1, "write answered");
		check(r, er, "write response");
	endtask

	task axi_read(input logic [addr_width-1:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		logic ar_hs, r_hs;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		r_hs = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_hs && n < 50)
		begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			n++;
			@(posedge aclk);
			if (ar_hs)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		check(r_hs, 1'b1, "read answered");
		check(d, {24'h000000, ed}, "read data");
		check(r, er, "read response");
	endtask

	task pulse_done;
		@(posedge aclk);
		conversion_done <= 1'b1;
		@(posedge aclk);
		conversion_done <= 1'b0;
		settle;
	endtask

	task test_defaults;
		axi_read(10'h058, 8'h00, resp_okay);
		axi_read(10'h060, 8'hff, resp_okay);
		axi_read(10'h064, 8'h37, resp_okay);
		axi_read(10'h068, 8'h00, resp_okay);
		check({aux_first, aux_second, active_channel_q, atten_a_q, atten_b_q}, 23'h00ff37, "outs");
		check({fan_one_step_q, fan_one_shift_q, fan_two_step_q, fan_two_shift_q}, 0, "fans");
	endtask

	task test_channels;
		for (int i = 0; i < 18; i++)
			if (i != 15)
			begin
				axi_write(10'h058, {i[4:0], 1'b1, i[1:0]}, resp_okay);
				settle;
				check(active_channel_q, i[4:0], "single channel");
				check({aux_first, aux_second}, {i[0], i[1]}, "aux enables");
			end
		pulse_done;
		check(active_channel_q, 5'h11, "single channel held");
	endtask

	task test_round_robin;
		int e;
		e = 0;
		axi_write(10'h100, 8'h02, resp_okay);
		settle;
		check(active_channel_q, 5'h00, "channel after soft reset");
		for (int k = 0; k < 19; k++)
		begin
			pulse_done;
			e = (e == 14) ? 16 : ((e == 17) ? 0 : e + 1);
			check(active_channel_q, e[4:0], "rotation");
		end
		axi_read(10'h104, {3'h0, e[4:0]}, resp_okay);
	endtask

	task test_atten;
		axi_write(10'h060, 8'h00, resp_okay);
		axi_read(10'h060, 8'h01, resp_okay);
		axi_write(10'h060, 8'h5a, resp_okay);
		axi_read(10'h060, 8'h5b, resp_okay);
		check(atten_a_q, 8'h5b, "attenuator a");
		axi_write(10'h064, 8'hc8, resp_okay);
		axi_read(10'h064, 8'hc8, resp_okay);
		check(atten_b_q, 8'hc8, "attenuator b");
	endtask

	task test_acoustics;
		for (int c = 0; c < 8; c++)
		begin
			@(posedge aclk);
			fan_one_slow <= c[0];
			fan_two_slow <= !c[0];
			axi_write(10'h068, {3'(7 - c), c[2:0], 2'b11}, resp_okay);
			settle;
			check({fan_one_step_q, fan_one_shift_q}, {step_exp[c], c[0] ? 2'd2 : 2'd0}, "fan one");
			check({fan_two_step_q, fan_two_shift_q}, {step_exp[7 - c], c[0] ? 2'd0 : 2'd2}, "fan two");
			axi_read(10'h068, {3'(7 - c), c[2:0], 2'b11}, resp_okay);
		end
		axi_write(10'h068, 8'hfc, resp_okay);
		settle;
		check({fan_one_step_q, fan_one_shift_q, fan_two_step_q, fan_two_shift_q}, 0, "off");
	endtask

	task test_reset_lock;
		axi_write(10'h0fc, 8'h55, resp_slverr);
		axi_read(10'h0fc, 8'h00, resp_slverr);
		axi_write(10'h058, 8'h03, resp_okay);
		axi_write(10'h100, 8'h02, resp_okay);
		test_defaults;
		axi_write(10'h100, 8'h01, resp_okay);
		axi_read(10'h100, 8'h01, resp_okay);
		axi_write(10'h058, 8'hff, resp_okay);
		axi_write(10'h064, 8'h00, resp_okay);
		axi_read(10'h058, 8'h00, resp_okay);
		axi_read(10'h064, 8'h37, resp_okay);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(10'h100, 8'h00, resp_okay);
		axi_write(10'h058, 8'h01, resp_okay);
		axi_read(10'h058, 8'h01, resp_okay);
	endtask

	initial
	begin
		#40000;
		check(32'h0, 32'h1, "watchdog expired");
		complete_run;
	end

	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		fan_one_slow = 1'b0;
		fan_two_slow = 1'b0;
		conversion_done = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		test_defaults;
		test_channels;
		test_round_robin;
		test_atten;
		test_acoustics;
		test_reset_lock;
		complete_run;
	end
endmodule // tb_monitor_conversion_fan_config
